// ==== rtl/pew_pkg.sv ====
// Constants and types for the parallel EEPROM write/poll host controller
package pew_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int STROBE_NS = 50;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACCESS_NS = 150;
	localparam int SYNC_CYC = 2;
	localparam int RD_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
	localparam int HZ_NS = 50;
	localparam int HZ_CYC = (HZ_NS + CLK_NS - 1) / CLK_NS;
	localparam int DW_US = 10;
	localparam int DW_CYC = (DW_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int WC_MS = 5;
	localparam int WC_CYC = (WC_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int BLC_US = 100;
	localparam int BLC_CYC = (BLC_US * 1000) / CLK_NS;
	// Margin so the pulse and recovery fit inside the byte load window
	localparam int BLC_MARGIN = 4 * STROBE_CYC;
	// ----------------------------------------------------------------
	// Geometry and status bits
	// ----------------------------------------------------------------
	localparam int AW = 15;
	localparam int DW = 8;
	localparam int PAGE_BYTES = 128;
	localparam int PAGE_LO = 7;
	localparam int PAGE_HI = 14;
	localparam int TOG_BIT = 6;
	localparam int CMP_BIT = 7;
	// Protection sequences: entries 0..2 unlock, 3..8 clear protection
	localparam logic [3:0] SEQ_PROT_END = 4'h3;
	localparam logic [3:0] SEQ_END = 4'h9;
	localparam logic [AW-1:0] SEQ_ADDR [0:8] = '{default: 15'h0000};
	localparam logic [DW-1:0] SEQ_DATA [0:8] = '{default: 8'h00};
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_UNPROT} pew_op_e;
	typedef struct packed {
		pew_op_e op;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
		logic last;
	} pew_cmd_s;
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [AW-1:0] addr;
		logic [DW-1:0] dq;
		logic dq_oe;
	} pew_pins_s;
endpackage

// ==== rtl/pew_host.sv ====
// Host controller driving a byte-wide parallel EEPROM through its pins
`timescale 1ns/1ps
// Summary of operation
// - Without polling, wait at least 5 ms before another write.
// - Any write may open a page; 1 to 127 further bytes may follow.
// - Page bytes keep address bits 7 to 14 of the first byte.
// - Each further byte load falls within 100 us of the previous one.
// - After polling reports completion, wait 10 us before writing.
// - Output drive may pulse between page loads for other reads or polls; the host instead ends the page on any other request and polls.
// - When protected, every byte or page write needs the unlock sequence.
// - Unlock is three fixed writes opening a one to 128 byte page.
// - Six fixed writes clear protection after one programming cycle.
module pew_host #(
	parameter int WC_CYC = pew_pkg::WC_CYC,
	parameter int BLC_CYC = pew_pkg::BLC_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic prot_en,
	input wire logic cmd_valid,
	input wire pew_pkg::pew_cmd_s cmd,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [pew_pkg::DW-1:0] rsp_data,
	output logic busy,
	output pew_pkg::pew_pins_s pins,
	input wire logic [pew_pkg::DW-1:0] dq_i
);
	typedef enum logic [2:0] {
		S_IDLE, S_WLO, S_WHI, S_RLO, S_RHI, S_PAGE, S_POLL, S_DLY
	} pew_state_e;

	pew_state_e st, next_st;
	logic [19:0] cnt, next_cnt, tmo, next_tmo;
	pew_pkg::pew_cmd_s cur, next_cur;
	pew_pkg::pew_pins_s next_pins;
	logic [3:0] idx, next_idx, stop, next_stop;
	logic pend, next_pend, held, next_held, polling, next_polling;
	logic have, next_have, tog, next_tog;
	logic [7:0] last_d, next_last_d, pg_cnt, next_pg_cnt, tag, next_tag;
	logic [14:0] last_a, next_last_a;
	logic [7:0] next_rsp_data;
	logic next_ready, next_rsp_valid, next_busy;
	logic [7:0] dq_m, dq_s;
	logic disp, wstart, rstart, tbl, done;
	logic [14:0] wa;
	logic [7:0] wd;

	// ----------------------------------------------------------------
	// Data input synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			dq_m <= 8'h00;
			dq_s <= 8'h00;
		end else if (en) begin
			dq_m <= dq_i;
			dq_s <= dq_m;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_tmo = tmo;
		next_cur = cur;
		next_pins = pins;
		next_idx = idx;
		next_stop = stop;
		next_pend = pend;
		next_held = held;
		next_polling = polling;
		next_have = have;
		next_tog = tog;
		next_last_d = last_d;
		next_last_a = last_a;
		next_pg_cnt = pg_cnt;
		next_tag = tag;
		next_rsp_data = rsp_data;
		next_rsp_valid = 1'h0;
		disp = 1'h0;
		wstart = 1'h0;
		rstart = 1'h0;
		wa = 15'h0000;
		wd = 8'h00;
		tbl = idx != stop;
		done = have && rsp_data[pew_pkg::TOG_BIT] == tog
			&& rsp_data[pew_pkg::CMP_BIT] == last_d[pew_pkg::CMP_BIT];
		if (polling) begin
			next_tmo = tmo + 20'h00001;
		end
		case (st)
			S_IDLE: begin
				// Ready is low for one cycle after reset; honour it
				if (cmd_valid && cmd_ready) begin
					next_cur = cmd;
					disp = 1'h1;
				end
			end
			S_WLO: begin
				if (cnt == 20'h00000) begin
					// Both strobes rise together, latching data
					next_pins.ce_n = 1'h1;
					next_pins.we_n = 1'h1;
					next_st = S_WHI;
					next_cnt = 20'(pew_pkg::STROBE_CYC - 1);
				end else begin
					next_cnt = cnt - 20'h00001;
				end
			end
			S_WHI: begin
				if (cnt == 20'h00000) begin
					next_pins.dq_oe = 1'h0;
					if (tbl) begin
						next_idx = idx + 4'h1;
						if (idx + 4'h1 != stop || pend) begin
							wstart = 1'h1;
						end else begin
							next_st = S_POLL;
						end
					end else begin
						next_pend = 1'h0;
						next_pg_cnt = pg_cnt + 8'h01;
						if (pg_cnt == 8'h00) begin
							next_tag = cur.addr[pew_pkg::PAGE_HI:pew_pkg::PAGE_LO];
						end
						// Close the page at the last byte or at full size
						if (cur.last || pg_cnt + 8'h01 == 8'(pew_pkg::PAGE_BYTES)) begin
							next_st = S_POLL;
						end else begin
							next_st = S_PAGE;
							next_cnt = 20'(BLC_CYC - pew_pkg::BLC_MARGIN);
						end
					end
				end else begin
					next_cnt = cnt - 20'h00001;
				end
			end
			S_PAGE: begin
				// Output drive stays high here; no status reads mid-page
				if (cmd_valid && cmd_ready) begin
					next_cur = cmd;
					if (cmd.op == pew_pkg::OP_WRITE && cmd.addr[pew_pkg::PAGE_HI:
						pew_pkg::PAGE_LO] == tag) begin
						next_pend = 1'h1;
						wstart = 1'h1;
					end else begin
						// Foreign request ends the page; served after completion
						next_held = 1'h1;
						next_st = S_POLL;
					end
				end else if (cnt == 20'h00000) begin
					next_st = S_POLL;
				end else begin
					next_cnt = cnt - 20'h00001;
				end
			end
			S_POLL: begin
				next_polling = 1'h1;
				next_have = 1'h0;
				next_tmo = 20'h00000;
				next_pg_cnt = 8'h00;
				rstart = 1'h1;
			end
			S_RLO: begin
				if (cnt == 20'h00000) begin
					next_rsp_data = dq_s;
					next_pins.ce_n = 1'h1;
					next_pins.oe_n = 1'h1;
					next_st = S_RHI;
					next_cnt = 20'(pew_pkg::HZ_CYC - 1);
				end else begin
					next_cnt = cnt - 20'h00001;
				end
			end
			S_RHI: begin
				if (cnt == 20'h00000) begin
					if (!polling) begin
						next_rsp_valid = 1'h1;
						next_st = S_IDLE;
					end else if (done || tmo >= 20'(WC_CYC)) begin
						next_polling = 1'h0;
						next_st = S_DLY;
						next_cnt = 20'(pew_pkg::DW_CYC - 1);
					end else begin
						next_have = 1'h1;
						next_tog = rsp_data[pew_pkg::TOG_BIT];
						rstart = 1'h1;
					end
				end else begin
					next_cnt = cnt - 20'h00001;
				end
			end
			S_DLY: begin
				if (cnt != 20'h00000) begin
					next_cnt = cnt - 20'h00001;
				end else if (held) begin
					next_held = 1'h0;
					disp = 1'h1;
				end else begin
					next_st = S_IDLE;
				end
			end
			default: next_st = S_IDLE;
		endcase
		if (disp) begin
			case (next_cur.op)
				pew_pkg::OP_READ: rstart = 1'h1;
				pew_pkg::OP_UNPROT: begin
					next_idx = pew_pkg::SEQ_PROT_END;
					next_stop = pew_pkg::SEQ_END;
					next_pend = 1'h0;
					wstart = 1'h1;
				end
				default: begin
					// Unlock prefix only when protection is in use
					next_idx = 4'h0;
					next_stop = prot_en ? pew_pkg::SEQ_PROT_END : 4'h0;
					next_pend = 1'h1;
					wstart = 1'h1;
				end
			endcase
		end
		if (wstart) begin
			wa = next_idx != next_stop ? pew_pkg::SEQ_ADDR[next_idx] : next_cur.addr;
			wd = next_idx != next_stop ? pew_pkg::SEQ_DATA[next_idx] : next_cur.data;
			// Address latched as both strobes fall together
			next_pins = '{1'h0, 1'h1, 1'h0, wa, wd, 1'h1};
			next_last_d = wd;
			next_last_a = wa;
			next_st = S_WLO;
			next_cnt = 20'(pew_pkg::STROBE_CYC - 1);
		end
		if (rstart) begin
			// Polls reread the last written address
			wa = next_polling ? next_last_a : next_cur.addr;
			next_pins = '{1'h0, 1'h0, 1'h1, wa, 8'h00, 1'h0};
			next_st = S_RLO;
			next_cnt = 20'(pew_pkg::RD_CYC - 1);
		end
		// No new request is taken while programming
		next_ready = next_st == S_IDLE || next_st == S_PAGE;
		next_busy = next_st != S_IDLE;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= S_IDLE;
			cnt <= 20'h00000;
			tmo <= 20'h00000;
			cur <= '0;
			pins <= '{1'h1, 1'h1, 1'h1, 15'h0000, 8'h00, 1'h0};
			idx <= 4'h0;
			stop <= 4'h0;
			pend <= 1'h0;
			held <= 1'h0;
			polling <= 1'h0;
			have <= 1'h0;
			tog <= 1'h0;
			last_d <= 8'h00;
			last_a <= 15'h0000;
			pg_cnt <= 8'h00;
			tag <= 8'h00;
			rsp_data <= 8'h00;
			rsp_valid <= 1'h0;
			cmd_ready <= 1'h0;
			busy <= 1'h0;
		end else if (en) begin
			st <= next_st;
			cnt <= next_cnt;
			tmo <= next_tmo;
			cur <= next_cur;
			pins <= next_pins;
			idx <= next_idx;
			stop <= next_stop;
			pend <= next_pend;
			held <= next_held;
			polling <= next_polling;
			have <= next_have;
			tog <= next_tog;
			last_d <= next_last_d;
			last_a <= next_last_a;
			pg_cnt <= next_pg_cnt;
			tag <= next_tag;
			rsp_data <= next_rsp_data;
			rsp_valid <= next_rsp_valid;
			cmd_ready <= next_ready;
			busy <= next_busy;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [19:0] gap;
	always_ff @(posedge clk) begin
		if (rst) begin
			gap <= 20'h00000;
		end else if (en) begin
			gap <= st == S_WLO ? 20'h00000 : gap + 20'h00001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_read_strobes: assert property (!pins.oe_n |-> !pins.ce_n && pins.we_n)
		else $error("output drive low outside a read");
	a_bus_release: assert property (pins.dq_oe |-> pins.oe_n)
		else $error("host drives data while output drive is low");
	a_write_inhibit: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n)
		else $error("write strobe low with wrong select or output drive");
	a_addr_stable: assert property ($fell(pins.we_n) |=> $stable(pins.addr) [*4])
		else $error("address moved during write pulse");
	a_data_latch: assert property ($rose(pins.we_n) |-> $stable(pins.dq) && pins.dq_oe)
		else $error("data not held at write strobe rise");
	a_page_size: assert property (pg_cnt <= 8'(pew_pkg::PAGE_BYTES))
		else $error("page exceeded its byte count");
	a_page_addr: assert property ($fell(pins.we_n) && pg_cnt != 8'h00 && idx == stop
		|-> pins.addr[14:7] == tag)
		else $error("page byte left the page");
	a_load_window: assert property (st == S_PAGE && next_st == S_WLO
		|-> gap + 20'(pew_pkg::STROBE_CYC) < 20'(BLC_CYC))
		else $error("byte load came too late");
	a_post_poll: assert property (en && st == S_RHI && next_st == S_DLY
		|=> st == S_DLY && cnt == 20'(pew_pkg::DW_CYC - 1))
		else $error("delay after polling cut short");
	a_poll_bound: assert property (polling |-> tmo <= 20'(WC_CYC) + 20'h00040)
		else $error("polling ran past the programming time");

	c_read: cover property (rsp_valid);
	c_page: cover property (st == S_PAGE ##[1:1000] st == S_WLO);
	c_unprot: cover property (st == S_WHI && idx == 4'h8);
	c_poll_done: cover property (st == S_RHI && polling && done && cnt == 20'h00000);
endmodule

// ==== verification/pew_eeprom_model.sv ====
// Behavioural model of the parallel EEPROM behind the host controller
`timescale 1ns/1ps
module pew_eeprom_model #(
	parameter int BLC_NS = 1000,
	parameter int PROG_NS = 1000,
	parameter int ACC_NS = 100
) (
	input wire pew_pkg::pew_pins_s pins,
	output logic [7:0] dq_o,
	output logic prot,
	output int n_prog
);
	// ----------------------------------------------------------------
	// Array, page buffer and protection state
	// ----------------------------------------------------------------
	logic [7:0] mem [0:32767];
	logic [7:0] out, lastd, pd [$];
	logic [14:0] cap_a, page_a, pa [$];
	logic drv, prog, tog, armed, open_w;
	int sqp, sqc;
	time last_we, t_end;
	wire rd_act = !pins.ce_n && !pins.oe_n;
	wire wr_act = !pins.ce_n && !pins.we_n && pins.oe_n;
	// Released lines show the inverse of the last value
	assign dq_o = (rd_act && drv) ? out : ~out;
	initial begin
		for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
		{out, lastd, drv, prog, tog, armed, open_w, prot} = '0;
		{sqp, sqc, n_prog, last_we} = '0;
	end
	always @(posedge rd_act) begin
		drv = 1'b0;
		// Status while programming or while a page is pending
		if (prog || pa.size() > 0) begin
			tog = ~tog;
			out = {~lastd[7], tog, lastd[5:0]};
		end else begin
			out = mem[pins.addr];
		end
		#ACC_NS drv = 1'b1;
	end
	always @(posedge wr_act) begin
		cap_a = pins.addr;
		last_we = $time;
		open_w = 1'b1;
	end
	always @(negedge wr_act) begin
		if (open_w && !prog) take(cap_a, pins.dq);
		open_w = 1'b0;
	end
	task automatic take(input logic [14:0] a, input logic [7:0] d);
		logic mu, mc;
		mu = sqp < 3 && a == pew_pkg::SEQ_ADDR[sqp] && d == pew_pkg::SEQ_DATA[sqp];
		mc = a == pew_pkg::SEQ_ADDR[3 + sqc] && d == pew_pkg::SEQ_DATA[3 + sqc];
		lastd = d;
		if (mu || mc) begin
			// Command writes never reach the array
			sqp = mu ? sqp + 1 : 0;
			sqc = mc ? sqc + 1 : 0;
			if (sqc == 6) begin
				{prot, sqc, sqp} = '0;
				prog = 1'b1;
				t_end = $time + PROG_NS;
			end
			return;
		end
		if (sqp == 3) {armed, prot} = 2'b11;
		{sqp, sqc} = '0;
		if (prot && !armed) return;
		if (pa.size() == 0) page_a = a;
		// Stray page bits land inside the first page
		pa.push_back({page_a[14:7], a[6:0]});
		pd.push_back(d);
		if (pa.size() == 128) begin
			prog = 1'b1;
			t_end = $time + PROG_NS;
		end
	endtask
	always begin
		#50;
		if (!prog && pa.size() > 0 && $time - last_we >= BLC_NS) begin
			prog = 1'b1;
			t_end = $time + PROG_NS;
		end
		if (prog && $time >= t_end) begin
			while (pa.size() > 0) mem[pa.pop_front()] = pd.pop_front();
			{prog, armed} = 2'b00;
			n_prog++;
		end
	end
endmodule

// ==== verification/tb.sv ====
// Self-checking testbench for the parallel EEPROM host controller
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
	logic clk, rst, en, prot_en, cmd_valid;
	pew_pkg::pew_cmd_s cmd;
	logic cmd_ready, rsp_valid, busy, prot;
	logic [7:0] rsp_data, dq_i, dq_o;
	pew_pkg::pew_pins_s pins;
	int errors = 0, n_compared = 0, cyc = 0, n_prog;
	pew_host #(.WC_CYC(2000), .BLC_CYC(100)) u_pew_host (.clk(clk),
		.rst(rst), .en(en), .prot_en(prot_en), .cmd_valid(cmd_valid),
		.cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .busy(busy), .pins(pins), .dq_i(dq_i));
	pew_eeprom_model #(.BLC_NS(1000), .PROG_NS(1000), .ACC_NS(100))
		u_pew_eeprom_model (.pins(pins), .dq_o(dq_o), .prot(prot),
		.n_prog(n_prog));
	// Host drive wins the shared data lines while it is enabled
	assign dq_i = pins.dq_oe ? pins.dq : dq_o;
	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic send(input pew_pkg::pew_op_e op, input logic [14:0] a,
		input logic [7:0] d, input logic last);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 5000) errors++;
		cmd_valid = 1'b1;
		cmd = '{op: op, addr: a, data: d, last: last};
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask
	task automatic wait_idle(output int n);
		n = 0;
		while (busy !== 1'b0 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 5000) errors++;
	endtask
	task automatic rd(input logic [14:0] a, input logic [7:0] exp);
		int n;
		send(pew_pkg::OP_READ, a, 8'h00, 1'b0);
		n = 1;
		while (rsp_valid !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		`CHK(n, 23)
		`CHK(rsp_data, exp)
	endtask
	task automatic wr1(input logic [14:0] a, input logic [7:0] d);
		int n;
		send(pew_pkg::OP_WRITE, a, d, 1'b1);
		wait_idle(n);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_byte();
		int n, p;
		p = n_prog;
		send(pew_pkg::OP_WRITE, 15'h0123, 8'hA5, 1'b1);
		wait_idle(n);
		// Polling must beat the 2000 cycle fallback
		`CHK(n >= 1000 && n < 1600, 1'b1)
		`CHK(n_prog, p + 1)
		rd(15'h0123, 8'hA5);
	endtask
	task automatic t_page();
		int n, p;
		p = n_prog;
		for (int i = 0; i < 4; i++) begin
			send(pew_pkg::OP_WRITE, 15'h0200 | 15'(i), 8'h81 + 8'(i), 1'(i == 3));
		end
		wait_idle(n);
		`CHK(n_prog, p + 1)
		for (int i = 0; i < 4; i++) begin
			rd(15'h0200 | 15'(i), 8'h81 + 8'(i));
		end
	endtask
	task automatic t_pages();
		int n, p;
		p = n_prog;
		send(pew_pkg::OP_WRITE, 15'h0410, 8'h90, 1'b0);
		send(pew_pkg::OP_WRITE, 15'h0490, 8'h91, 1'b1);
		wait_idle(n);
		`CHK(n_prog, p + 2)
		rd(15'h0410, 8'h90);
		rd(15'h0490, 8'h91);
		send(pew_pkg::OP_WRITE, 15'h0520, 8'hC1, 1'b0);
		wait_idle(n);
		`CHK(n_prog, p + 3)
		rd(15'h0520, 8'hC1);
	endtask
	task automatic t_prot();
		int n;
		prot_en = 1'b1;
		wr1(15'h0300, 8'hB3);
		`CHK(prot, 1'b1)
		prot_en = 1'b0;
		wr1(15'h0301, 8'hC4);
		rd(15'h0301, 8'h00);
		prot_en = 1'b1;
		wr1(15'h0302, 8'hD5);
		rd(15'h0302, 8'hD5);
		prot_en = 1'b0;
		send(pew_pkg::OP_UNPROT, 15'h0000, 8'h00, 1'b1);
		wait_idle(n);
		`CHK(prot, 1'b0)
		wr1(15'h0303, 8'hE6);
		rd(15'h0303, 8'hE6);
	endtask
	task automatic finish_test();
		if (errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(negedge clk) begin
		if (!rst && pins.we_n === 1'b0) `CHK(pins.oe_n, 1'b1)
		if (!rst && pins.oe_n === 1'b0) `CHK(pins.dq_oe, 1'b0)
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst, en, prot_en, cmd_valid} = 4'b1100;
		cmd = '0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		`CHK(prot, 1'b0)
		t_byte();
		t_page();
		t_pages();
		t_prot();
		finish_test();
	end
endmodule
